// *** verilog/static_mem_pkg.sv ***
/*
 static memory port package: strap codes, bank decode defaults, request and
 configuration carriers shared by the port and its bench.
 assumes a 32-bit byte address from the on-chip master and a 10 MHz clock.
*/
package static_mem_pkg;

    // boot bank width strap codes
    localparam logic [1:0] WIDTH_RESERVED = 2'h0;
    localparam logic [1:0] WIDTH_8 = 2'h1;
    localparam logic [1:0] WIDTH_16 = 2'h2;
    localparam logic [1:0] WIDTH_32 = 2'h3;

    // default region bases and sizes (byte addresses)
    localparam logic [31:0] BANK0_BASE = 32'h0000_0000;
    localparam logic [31:0] BANK0_SIZE = 32'h0200_0000;
    localparam logic [31:0] BANK1_BASE = 32'h0210_0000;
    localparam logic [31:0] BANK1_SIZE = 32'h0080_0000;
    localparam logic [31:0] IO_BASE = 32'h0290_0000;
    localparam logic [31:0] IO_BANK_SIZE = 32'h0000_4000;

    // access timing in cycles, programmed default
    localparam logic [3:0] ACCESS_CYCLES_RESET = 4'h3;

    // reset values of the pins
    localparam logic [1:0] BANK_SEL_IDLE = 2'h3;
    localparam logic [2:0] IO_SEL_IDLE = 3'h7;
    localparam logic [3:0] WRITE_EN_IDLE = 4'hF;

    typedef struct packed {
        logic        write;
        logic [31:0] addr;
        logic [3:0]  byte_en;
        logic [31:0] wdata;
    } mem_req_t;

    typedef struct packed {
        logic [1:0] boot_width;
        logic       watchdog_high;
    } strap_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ACCESS = 2'b01,
        ST_DONE = 2'b10
    } port_state_t;

endpackage

// *** verilog/static_memory_io_interface.sv ***
/*
 static memory and external i/o port: bank selects, read output enable,
 byte write enables, access extension by wait input, reset straps.
 assumes one request at a time from the master, held until done pulses;
 shared strap pins are driven by the board throughout reset.
*/
`timescale 1ns/10ps
module static_memory_io_interface #(
    parameter logic [3:0] ACCESS_CYCLES = static_mem_pkg::ACCESS_CYCLES_RESET
) (
    // system
    input wire logic clk,
    input wire logic rst,
    // master request side
    input wire logic req_valid,
    input wire static_mem_pkg::mem_req_t req,
    input wire logic req_sdram,
    output logic req_done,
    output logic [31:0] rdata,
    output logic bad_width,
    // straps seen by the rest of the chip
    output static_mem_pkg::strap_t straps,
    output logic [1:0] boot_bus_width,
    // memory pins
    input wire logic access_extend_n,
    input wire logic [31:0] data_in,
    output logic [31:0] data_out,
    output logic data_oe,
    output logic [21:0] addr_out,
    output logic [1:0] static_bank_select_n,
    output logic [2:0] io_bank_select_n,
    output logic static_read_output_enable_n,
    output logic static_read_output_enable_oe,
    input wire logic watchdog_reset_polarity_strap,
    input wire logic [1:0] boot_bank_width_strap,
    output logic [3:0] static_byte_write_enable_n,
    output logic boot_strap_pins_oe
);

    ////////////////////////////////////////////////////////////////////////
    // decode helpers

    function automatic logic in_region(input logic [31:0] a, input logic [31:0] base,
                                       input logic [31:0] size);
        in_region = (a >= base) && (a < base + size);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // strap capture: sync during reset, freeze at release

    logic [2:0] strap_s1_reg, strap_s2_reg, strap_s1_next, strap_s2_next;
    static_mem_pkg::strap_t strap_reg, strap_next;
    logic rst_seen_reg, rst_seen_next;

    always_comb begin
        strap_s1_next = {boot_bank_width_strap, watchdog_reset_polarity_strap};
        strap_s2_next = strap_s1_reg;
        strap_next = strap_reg;
        rst_seen_next = 1'b1;
        // keep following the pins in reset and up to the first edge after release
        if (rst || !rst_seen_reg) begin
            strap_next.boot_width = strap_s2_reg[2:1];
            strap_next.watchdog_high = strap_s2_reg[0];
        end
    end

    // async reset clears rst_seen so the edge after release still samples
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rst_seen_reg <= 1'b0;
        end else begin
            rst_seen_reg <= rst_seen_next;
        end
    end

    // synchroniser and straps carry no reset: a reset would hide the pins
    // exactly while they are meant to be sampled
    always_ff @(posedge clk) begin
        strap_s1_reg <= strap_s1_next;
        strap_s2_reg <= strap_s2_next;
        strap_reg <= strap_next;
    end

    ////////////////////////////////////////////////////////////////////////
    // access sequencer

    logic ext_s1_reg, ext_s2_reg, ext_s1_next, ext_s2_next;
    static_mem_pkg::port_state_t state_reg, state_next;
    logic [3:0] count_reg, count_next;
    logic [1:0] bank_sel_reg, bank_sel_next;
    logic [2:0] io_sel_reg, io_sel_next;
    logic oe_n_reg, oe_n_next;
    logic [3:0] we_n_reg, we_n_next;
    logic [31:0] rdata_reg, rdata_next, dout_reg, dout_next;
    logic dout_oe_reg, dout_oe_next, done_reg, done_next, bad_reg, bad_next;
    logic [21:0] addr_reg, addr_next;
    logic pins_live_reg, pins_live_next;
    logic hit_b0, hit_b1, hit_io;
    logic [31:0] io_off;

    always_comb begin
        ext_s1_next = access_extend_n;
        ext_s2_next = ext_s1_reg;
        hit_b0 = in_region(req.addr, static_mem_pkg::BANK0_BASE, static_mem_pkg::BANK0_SIZE);
        hit_b1 = in_region(req.addr, static_mem_pkg::BANK1_BASE, static_mem_pkg::BANK1_SIZE);
        io_off = req.addr - static_mem_pkg::IO_BASE;
        hit_io = in_region(req.addr, static_mem_pkg::IO_BASE, 3 * static_mem_pkg::IO_BANK_SIZE);
        state_next = state_reg;
        count_next = count_reg;
        bank_sel_next = bank_sel_reg;
        io_sel_next = io_sel_reg;
        oe_n_next = oe_n_reg;
        we_n_next = we_n_reg;
        rdata_next = rdata_reg;
        dout_next = dout_reg;
        dout_oe_next = dout_oe_reg;
        addr_next = addr_reg;
        done_next = 1'b0;
        bad_next = bad_reg;
        pins_live_next = 1'b1;
        unique case (state_reg)
            static_mem_pkg::ST_IDLE: begin
                // sdram requests belong to another controller: no strobe here
                if (req_valid && !req_sdram && (hit_b0 || hit_b1 || hit_io)) begin
                    state_next = static_mem_pkg::ST_ACCESS;
                    count_next = ACCESS_CYCLES;
                    addr_next = req.addr[21:0];
                    if (hit_b0) begin
                        bank_sel_next = 2'b10;
                        // boot bank at strapped width; reserved code flagged
                        bad_next = (strap_reg.boot_width == static_mem_pkg::WIDTH_RESERVED);
                    end else if (hit_b1) begin
                        bank_sel_next = 2'b01;
                    end else if (io_off < static_mem_pkg::IO_BANK_SIZE) begin
                        io_sel_next = 3'b110;
                    end else if (io_off < 2 * static_mem_pkg::IO_BANK_SIZE) begin
                        io_sel_next = 3'b101;
                    end else begin
                        io_sel_next = 3'b011;
                    end
                    if (req.write) begin
                        we_n_next = ~req.byte_en;
                        dout_next = req.wdata;
                        dout_oe_next = 1'b1;
                    end else begin
                        oe_n_next = 1'b0;
                    end
                end else if (req_valid) begin
                    done_next = 1'b1;
                    state_next = static_mem_pkg::ST_DONE;
                end
            end
            static_mem_pkg::ST_ACCESS: begin
                if (count_reg != 4'h0) begin
                    count_next = count_reg - 4'h1;
                end else if (ext_s2_reg) begin
                    // wait released: close the strobe and return data
                    // only reads load data: a write leaves the bus undriven by the device
                    if (!oe_n_reg) begin
                        rdata_next = data_in;
                    end
                    bank_sel_next = static_mem_pkg::BANK_SEL_IDLE;
                    io_sel_next = static_mem_pkg::IO_SEL_IDLE;
                    oe_n_next = 1'b1;
                    we_n_next = static_mem_pkg::WRITE_EN_IDLE;
                    dout_oe_next = 1'b0;
                    done_next = 1'b1;
                    state_next = static_mem_pkg::ST_DONE;
                end
                // else hold: wait input low stretches the access
            end
            static_mem_pkg::ST_DONE: begin
                // this cycle and the ST_IDLE cycle give two idle cycles between strobes, master drops request
                state_next = static_mem_pkg::ST_IDLE;
            end
            default: state_next = static_mem_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ext_s1_reg <= 1'b1;
            ext_s2_reg <= 1'b1;
            state_reg <= static_mem_pkg::ST_IDLE;
            count_reg <= 4'h0;
            bank_sel_reg <= static_mem_pkg::BANK_SEL_IDLE;
            io_sel_reg <= static_mem_pkg::IO_SEL_IDLE;
            oe_n_reg <= 1'b1;
            we_n_reg <= static_mem_pkg::WRITE_EN_IDLE;
            rdata_reg <= 32'h0;
            dout_reg <= 32'h0;
            dout_oe_reg <= 1'b0;
            addr_reg <= 22'h0;
            done_reg <= 1'b0;
            bad_reg <= 1'b0;
            pins_live_reg <= 1'b0;
        end else begin
            ext_s1_reg <= ext_s1_next;
            ext_s2_reg <= ext_s2_next;
            state_reg <= state_next;
            count_reg <= count_next;
            bank_sel_reg <= bank_sel_next;
            io_sel_reg <= io_sel_next;
            oe_n_reg <= oe_n_next;
            we_n_reg <= we_n_next;
            rdata_reg <= rdata_next;
            dout_reg <= dout_next;
            dout_oe_reg <= dout_oe_next;
            addr_reg <= addr_next;
            done_reg <= done_next;
            bad_reg <= bad_next;
            pins_live_reg <= pins_live_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign req_done = done_reg;
    assign rdata = rdata_reg;
    assign bad_width = bad_reg;
    assign straps = strap_reg;
    assign boot_bus_width = strap_reg.boot_width;
    assign data_out = dout_reg;
    assign data_oe = dout_oe_reg;
    assign addr_out = addr_reg;
    assign static_bank_select_n = bank_sel_reg;
    assign io_bank_select_n = io_sel_reg;
    assign static_read_output_enable_n = oe_n_reg;
    // strap pins left undriven in reset so the board level is read
    assign static_read_output_enable_oe = pins_live_reg;
    assign boot_strap_pins_oe = pins_live_reg;
    assign static_byte_write_enable_n = we_n_reg;

endmodule

// *** test/static_mem_chk.sv ***
/*
 pin checker for the static memory port.
 assumes the master holds each request until done, and a bind at the foot.
*/
`timescale 1ns/10ps
module static_mem_chk (
    // system and master side
    input wire logic clk,
    input wire logic rst,
    input wire logic req_valid,
    input wire static_mem_pkg::mem_req_t req,
    input wire logic req_sdram,
    input wire logic req_done,
    input wire static_mem_pkg::strap_t straps,
    input wire logic [1:0] boot_bus_width,
    // memory pins
    input wire logic access_extend_n,
    input wire logic [1:0] static_bank_select_n,
    input wire logic [2:0] io_bank_select_n,
    input wire logic static_read_output_enable_n,
    input wire logic static_read_output_enable_oe,
    input wire logic [3:0] static_byte_write_enable_n,
    input wire logic boot_strap_pins_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence read_start;
        $fell(static_read_output_enable_n);
    endsequence
    // bound covers the longest wait the partner makes plus the sync delay
    sequence done_soon;
        ##[1:40] req_done;
    endsequence
    a_select_unique: assert property (
        $onehot0({~static_bank_select_n, ~io_bank_select_n}))
        else $error("more than one select low");
    a_pins_late: assert property ($fell(rst) |->
        !boot_strap_pins_oe && !static_read_output_enable_oe)
        else $error("shared pins driven before release");
    a_straps_frozen: assert property (!$past(rst) && !$past(rst, 2) |-> $stable(straps))
        else $error("straps changed after reset");
    a_done_bound: assert property (read_start |-> done_soon)
        else $error("read never finished");
    a_sel_stable: assert property (static_bank_select_n != 2'h3 |=>
        static_bank_select_n == $past(static_bank_select_n) || req_done)
        else $error("bank select moved in an access");
    a_sdram_quiet: assert property (req_valid && req_sdram |->
        static_bank_select_n == 2'h3 && io_bank_select_n == 3'h7 &&
        static_byte_write_enable_n == 4'hF)
        else $error("strobe on an sdram access");
    a_we_bytes: assert property (static_byte_write_enable_n != 4'hF |->
        req.write && static_byte_write_enable_n == ~req.byte_en)
        else $error("write enables do not match bytes");
    a_oe_read: assert property (!static_read_output_enable_n |->
        !req.write && !req_sdram &&
        (static_bank_select_n != 2'h3 || io_bank_select_n != 3'h7))
        else $error("output enable outside a read");
    a_wait_stretch: assert property (!access_extend_n |=> !req_done)
        else $error("access ended while wait held");
    a_width_copy: assert property (boot_bus_width == straps.boot_width)
        else $error("boot width differs from strap");
endmodule
bind static_memory_io_interface static_mem_chk chk (.clk, .rst, .req_valid, .req, .req_sdram,
    .req_done, .straps, .boot_bus_width, .access_extend_n, .static_bank_select_n,
    .io_bank_select_n, .static_read_output_enable_n, .static_read_output_enable_oe,
    .static_byte_write_enable_n, .boot_strap_pins_oe);

// *** test/mem_partner.sv ***
/*
 external memory and i/o device model: answers reads, holds wait low.
 assumes one access at a time; wait length set by the bench.
*/
`timescale 1ns/10ps
module mem_partner (
    // pins from the port
    input wire logic clk,
    input wire logic [1:0] static_bank_select_n,
    input wire logic [2:0] io_bank_select_n,
    input wire logic static_read_output_enable_n,
    input wire logic [21:0] addr_out,
    // bench control, pins back
    input wire logic [3:0] wait_len,
    output logic [31:0] data_in,
    output logic access_extend_n
);
    logic act;
    logic [3:0] cnt;
    logic [31:0] word;
    assign act = static_bank_select_n != 2'h3 || io_bank_select_n != 3'h7;
    assign word = {10'h15B, addr_out};
    // a released bus shows the inverse so a late sample cannot match
    assign data_in = static_read_output_enable_n ? ~word : word;
    assign access_extend_n = !(act && cnt < wait_len);
    always @(posedge clk) begin
        cnt <= act ? cnt + 4'h1 : 4'h0;
    end
endmodule

// *** test/static_memory_io_interface_bench.sv ***
/*
 bench for the static memory port: reference decode model and straps.
 assumes the checker binds itself and the partner answers the pins.
*/
`timescale 1ns/10ps
module static_memory_io_interface_bench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic req_valid = 1'b0;
    static_mem_pkg::mem_req_t req = '0;
    logic req_sdram = 1'b0;
    logic pol_pin = 1'b0;
    logic [1:0] width_pin = 2'h1;
    logic [3:0] wait_len = 4'h0;
    logic req_done, bad_width, data_oe, oe_en, pins_en, ext_n, oe_n, pol_wire, exp_bad;
    logic [31:0] rdata, data_in, data_out, exp_rdata;
    logic [21:0] addr_out;
    logic [1:0] sel_n, boot_bus_width, sel_seen, exp_width;
    logic [2:0] io_n, io_seen;
    logic [3:0] we_n, we_seen;
    logic oe_seen, doe_seen;
    logic [31:0] dout_seen;
    static_mem_pkg::strap_t straps;
    integer fails = 0;
    integer n_tests = 0;
    integer seed = 32'hd6ef;
    logic [31:0] addrs [9] = '{32'h0, 32'h01FF_FFFC, 32'h0210_0000, 32'h028F_FFFC,
        32'h0290_0000, 32'h0290_4000, 32'h0290_BFFC, 32'h0290_C000, 32'h0200_0000};
    always #50 clk = ~clk;
    // one pad: the board strap shows only while the port leaves it undriven
    assign pol_wire = oe_en ? oe_n : pol_pin;
    static_memory_io_interface #(.ACCESS_CYCLES(4'h3)) DUT (.clk(clk), .rst(rst),
        .req_valid(req_valid), .req(req), .req_sdram(req_sdram), .req_done(req_done),
        .rdata(rdata), .bad_width(bad_width), .straps(straps), .boot_bus_width(boot_bus_width),
        .access_extend_n(ext_n), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
        .addr_out(addr_out), .static_bank_select_n(sel_n), .io_bank_select_n(io_n),
        .static_read_output_enable_n(oe_n), .static_read_output_enable_oe(oe_en),
        .watchdog_reset_polarity_strap(pol_wire), .boot_bank_width_strap(width_pin),
        .static_byte_write_enable_n(we_n), .boot_strap_pins_oe(pins_en));
    mem_partner far (.clk(clk), .static_bank_select_n(sel_n), .io_bank_select_n(io_n),
        .static_read_output_enable_n(oe_n), .addr_out(addr_out), .wait_len(wait_len),
        .data_in(data_in), .access_extend_n(ext_n));
    // strobes seen low during the current request
    always @(posedge clk) begin
        sel_seen <= req_valid ? sel_seen & sel_n : 2'h3;
        io_seen <= req_valid ? io_seen & io_n : 3'h7;
        we_seen <= req_valid ? we_seen & we_n : 4'hF;
        oe_seen <= req_valid ? oe_seen & oe_n : 1'b1;
        doe_seen <= req_valid ? doe_seen | data_oe : 1'b0;
        dout_seen <= data_oe ? data_out : dout_seen;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t %s seen %h exp %h", $time, what, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    function automatic int bank_of(input logic [31:0] a, input logic sd);
        if (sd) return -1;
        if (a < 32'h0200_0000) return 0;
        if (a >= 32'h0210_0000 && a < 32'h0290_0000) return 1;
        if (a >= 32'h0290_0000 && a < 32'h0290_C000) return 2 + (a - 32'h0290_0000) / 32'h4000;
        return -1;
    endfunction
    task automatic do_reset(input logic [1:0] w, input logic p);
        @(posedge clk);
        rst <= 1'b1;
        width_pin <= w;
        pol_pin <= p;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        exp_bad = 1'b0;
        exp_rdata = 32'h0;
        exp_width = w;
        @(negedge clk);
        check({oe_en, pins_en}, 2'h0, "pins before release");
        @(negedge clk);
        check({oe_en, pins_en}, 2'h3, "pins after release");
        @(posedge clk);
        width_pin <= ~w;
        pol_pin <= ~p;
        repeat (4) @(negedge clk);
        check(straps, {w, p}, "straps");
        check(boot_bus_width, w, "boot width");
    endtask
    task automatic access(input logic wr, input logic [31:0] a, input logic sd);
        int k;
        logic [3:0] be;
        logic [31:0] wd;
        be = 4'($random(seed));
        wd = $random(seed);
        k = bank_of(a, sd);
        @(posedge clk);
        wait_len <= 4'({$random(seed)} % 6);
        req_valid <= 1'b1;
        req <= '{wr, a, be, wd};
        req_sdram <= sd;
        for (int i = 0; i < 40 && req_done !== 1'b1; i++) @(negedge clk);
        check(req_done, 1'b1, "done");
        check(sel_seen, k == 0 ? 2'h2 : k == 1 ? 2'h1 : 2'h3, "bank select");
        check(io_seen, k > 1 ? 3'(~(3'h1 << (k - 2))) : 3'h7, "io select");
        check(we_seen, wr && k >= 0 ? 4'(~be) : 4'hF, "byte enables");
        check(doe_seen, wr && k >= 0, "data drive");
        if (wr && k >= 0) check(dout_seen, wd, "write data");
        check(oe_seen, wr || k < 0, "output enable");
        if (!wr && k >= 0) exp_rdata = {10'h15B, a[21:0]};
        if (!wr) check(rdata, exp_rdata, "read data");
        if (k == 0) exp_bad = exp_width == static_mem_pkg::WIDTH_RESERVED;
        check(bad_width, exp_bad, "reserved width");
        @(posedge clk);
        req_valid <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    initial begin
        for (int s = 0; s < 4; s++) begin
            do_reset(2'(s), s[0]);
            for (int i = 0; i < 9; i++) begin
                access(1'b1, addrs[i], 1'b0);
                access(1'b0, addrs[i], 1'b0);
            end
            access(1'b1, 32'h0010_0000, 1'b1);
            access(1'b0, 32'h0010_0000, 1'b1);
            repeat (6) access(1'($random(seed)), {$random(seed)} % 32'h0300_0000, 1'b0);
            $display("test strap %0d done", s);
        end
        summarize();
    end
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        summarize();
    end
endmodule
